// File: hdl/sfpi_buf2.sv
`timescale 1ns/1ps
// Two-entry buffer with valid and ready on both sides.
module sfpi_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    // Full and empty come from one count so they never disagree.
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_data;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// File: hdl/sfpi_pkg.sv
// Contract
// - Serial output bits change after each falling edge of the serial clock.
// - Serial input bits are captured on each rising edge of the serial clock.
// - Parallel port samples on rising edge and drives on falling edge.
// - Select low means active; select high deselects and floats serial output.
// - Commands are ignored until a select falling edge follows power-up.
// - Standby only when deselected and no internal write operation is busy.
// - Pause low suspends transfer, floats output, ignores input and clock.
// - Protect low refuses program or erase inside the protected area.
// - High voltage on protect pin selects accelerated programming mode.
// - Link runs in mode 0 or mode 3 only.
// - Information moves in whole bytes of eight bits.
package sfpi_pkg;

    // ------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------
    localparam int unsigned SFPI_BYTE_BITS = 8;
    localparam logic [2:0] SFPI_BIT_LAST = 3'h7;
    localparam logic [2:0] SFPI_BIT_FIRST = 3'h0;
    localparam logic [7:0] SFPI_BYTE_RESET = 8'h00;
    localparam logic [7:0] SFPI_IDLE_FILL = 8'hFF;

    // ------------------------------------------------------------
    // Link states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SFPI_ST_LOCKED = 4'h1,
        SFPI_ST_IDLE = 4'h2,
        SFPI_ST_XFER = 4'h4,
        SFPI_ST_PAUSE = 4'h8
    } sfpi_state_t;

endpackage

// File: hdl/sfpi_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a vector of pin levels.
module sfpi_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] meta_q;

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    // The first stage is read only by the second stage.
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= INIT;
            level <= INIT;
        end else begin
            meta_q <= pin;
            level <= meta_q;
        end
    end
endmodule

// File: hdl/sfpi_top.sv
`timescale 1ns/1ps
// Pin-level serial link of the flash device. Bytes arriving on the serial
// or parallel inputs are handed to the core through a two-entry buffer;
// bytes the core offers are shifted out. All pins are oversampled by the
// system clock, so the serial clock must stay well below a quarter of it.
module sfpi_top
    import sfpi_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic device_select_n,
    input wire logic pause_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic [7:0] parallel_io_in,
    output logic [7:0] parallel_io_out,
    output logic [7:0] parallel_io_oe,
    input wire logic parallel_mode,
    input wire logic protect_accel_n,
    input wire logic accel_voltage,
    input wire logic addr_protected,
    input wire logic write_busy,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_first,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic selected,
    output logic standby,
    output logic write_refused,
    output logic accel_mode,
    output logic overrun
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] pio_s;
    logic sck_s;
    logic cs_n_s;
    logic pause_n_s;
    logic si_s;
    logic wp_n_s;
    logic hv_s;

    // The control stage starts with select low and pause high. A select pin
    // that is already low when reset ends therefore shows no falling edge,
    // so the device stays locked until the controller deselects and then
    // selects it again. Starting high here would invent a select edge as
    // soon as the real pin level arrives.
    sfpi_sync #(.WIDTH(6), .INIT(6'h0E)) u_sync_ctl (
        .clock(clock),
        .reset(reset),
        .pin({serial_clk, device_select_n, pause_n, serial_in,
              protect_accel_n, accel_voltage}),
        .level({sck_s, cs_n_s, pause_n_s, si_s, wp_n_s, hv_s})
    );

    sfpi_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_pio (
        .clock(clock),
        .reset(reset),
        .pin(parallel_io_in),
        .level(pio_s)
    );

    // The serial clock is sampled like data, so each of its levels must
    // last at least two system clocks for both edges to be seen once.

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic sck_q;
    logic cs_n_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;

    // Only the edges of the serial clock matter, never its idle level, so
    // mode 0 and mode 3 are handled alike: inputs on rising edges, outputs
    // on falling edges, whichever level the clock rests at.
    // The select history starts low to match its synchroniser.
    always_ff @(posedge clock) begin
        if (reset) begin
            sck_q <= 1'b0;
            cs_n_q <= 1'b0;
        end else begin
            sck_q <= sck_s;
            cs_n_q <= cs_n_s;
        end
    end

    // Clock edges count only while selected and not paused.
    assign sck_rise = sck_s && !sck_q && !cs_n_s && pause_n_s;
    assign sck_fall = !sck_s && sck_q && !cs_n_s && pause_n_s;
    assign cs_fall = !cs_n_s && cs_n_q;
    assign cs_rise = cs_n_s && !cs_n_q;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    sfpi_state_t state_q;
    sfpi_state_t state_d;
    logic armed_q;

    // Locked and idle differ only in how they were reached: locked is the
    // state after reset, before the controller has shown a select edge.
    // Keeping them apart makes the power-up rule visible in the encoding.
    // Nothing is accepted until the first select falling edge.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SFPI_ST_LOCKED: begin
                if (cs_fall) begin
                    state_d = SFPI_ST_XFER;
                end
            end
            SFPI_ST_IDLE: begin
                if (cs_fall) begin
                    state_d = SFPI_ST_XFER;
                end
            end
            SFPI_ST_XFER: begin
                if (cs_rise) begin
                    state_d = SFPI_ST_IDLE;
                end else if (!pause_n_s) begin
                    state_d = SFPI_ST_PAUSE;
                end
            end
            SFPI_ST_PAUSE: begin
                // Pause only matters while selected; a deselect ends it.
                if (cs_rise) begin
                    state_d = SFPI_ST_IDLE;
                end else if (pause_n_s) begin
                    state_d = SFPI_ST_XFER;
                end
            end
            default: state_d = SFPI_ST_LOCKED;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= SFPI_ST_LOCKED;
            armed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (cs_fall) begin
                armed_q <= 1'b1;
            end
        end
    end

    wire in_frame = (state_q == SFPI_ST_XFER) && !cs_n_s;
    wire active = in_frame && pause_n_s && armed_q;

    // ------------------------------------------------------------
    // Receive shifter
    // ------------------------------------------------------------
    logic [7:0] rx_sh_q;
    logic [2:0] bit_q;
    logic first_q;
    logic push_q;
    logic [7:0] push_data_q;
    logic push_first_q;
    logic buf_in_ready;
    logic [7:0] rx_sh_next;

    // MSB first: the new bit enters at the bottom.
    assign rx_sh_next = parallel_mode ? pio_s : {rx_sh_q[6:0], si_s};
    wire byte_done = parallel_mode || (bit_q == SFPI_BIT_LAST);

    // A select falling edge clears the bit count, so a byte cut short by a
    // deselect is discarded rather than merged with the next frame.
    // A serial byte completes only after eight rising edges; in parallel mode each rising edge completes one.
    always_ff @(posedge clock) begin
        if (reset || cs_fall) begin
            rx_sh_q <= SFPI_BYTE_RESET;
            bit_q <= SFPI_BIT_FIRST;
            first_q <= 1'b1;
            push_q <= 1'b0;
            push_data_q <= SFPI_BYTE_RESET;
            push_first_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (active && sck_rise) begin
                rx_sh_q <= rx_sh_next;
                bit_q <= byte_done ? SFPI_BIT_FIRST : bit_q + 3'h1;
                if (byte_done) begin
                    push_q <= 1'b1;
                    push_data_q <= rx_sh_next;
                    push_first_q <= first_q;
                    first_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    // The ninth bit marks the first byte of a frame and rides with it.
    logic [8:0] buf_out_data;
    logic buf_out_valid;
    logic rx_valid_pend;

    sfpi_buf2 #(.WIDTH(9)) u_rx_buf (
        .clock(clock),
        .reset(reset),
        .in_valid(push_q),
        .in_ready(buf_in_ready),
        .in_data({push_first_q, push_data_q}),
        .out_valid(buf_out_valid),
        .out_ready(rx_ready && !rx_valid_pend),
        .out_data(buf_out_data)
    );

    // Output stage register keeps every top output on a flip-flop. A held
    // byte blocks the buffer's read side so it cannot be overwritten.
    assign rx_valid_pend = rx_valid && !rx_ready;

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_valid <= 1'b0;
            rx_data <= SFPI_BYTE_RESET;
            rx_first <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (!rx_valid_pend) begin
                rx_valid <= buf_out_valid && rx_ready;
                rx_data <= buf_out_data[7:0];
                rx_first <= buf_out_data[8];
            end
            // The link cannot stall, so a full buffer drops the byte.
            if (push_q && !buf_in_ready) begin
                overrun <= 1'b1;
            end else if (cs_fall) begin
                overrun <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit shifter
    // ------------------------------------------------------------
    logic [7:0] tx_sh_q;
    logic [2:0] tx_bit_q;
    wire tx_load = active && sck_fall && (parallel_mode ||
                   tx_bit_q == SFPI_BIT_FIRST);

    // The first falling edge of a byte loads the core's word; if the core
    // has nothing ready, ones go out, which the controller reads as idle.
    // The trade-off is that a late core word waits for the next byte.
    // Data moves out on falling edges, MSB first.
    always_ff @(posedge clock) begin
        if (reset || cs_fall) begin
            tx_sh_q <= SFPI_IDLE_FILL;
            tx_bit_q <= SFPI_BIT_FIRST;
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= tx_load && !tx_ready;
            if (active && sck_fall) begin
                if (tx_load) begin
                    tx_sh_q <= tx_valid ? tx_data : SFPI_IDLE_FILL;
                end else begin
                    tx_sh_q <= {tx_sh_q[6:0], 1'b1};
                end
                tx_bit_q <= parallel_mode ? SFPI_BIT_FIRST :
                            tx_bit_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers and status
    // ------------------------------------------------------------
    // Every pin output and every status flag but overrun is registered here, one clock after the
    // internal state, so the enables never glitch while a level settles.
    // Standby follows the select pin and the core's busy flag together.
    always_ff @(posedge clock) begin
        if (reset) begin
            serial_out <= 1'b1;
            serial_out_oe <= 1'b0;
            parallel_io_out <= SFPI_BYTE_RESET;
            parallel_io_oe <= SFPI_BYTE_RESET;
            selected <= 1'b0;
            standby <= 1'b1;
            write_refused <= 1'b0;
            accel_mode <= 1'b0;
        end else begin
            serial_out <= tx_sh_q[7];
            serial_out_oe <= active && !parallel_mode;
            parallel_io_out <= tx_sh_q;
            parallel_io_oe <= {SFPI_BYTE_BITS{active && parallel_mode}};
            selected <= !cs_n_s;
            standby <= cs_n_s && !write_busy;
            write_refused <= !wp_n_s && addr_protected;
            accel_mode <= hv_s;
        end
    end
endmodule

// File: sim/sfpi_master.sv
`timescale 1ns/1ps
// --------------------
// Mode 0 link master
// --------------------
module sfpi_master (
    input wire logic clock,
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    localparam int HALF = 10;
    // Select is low at power-up, so no falling edge has been seen yet.
    initial begin
        sck = 1'b0;
        cs_n = 1'b0;
        si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Each select change shows junk on the data line, the inverse of its last bit.
    task automatic sel(input logic on);
        tick(HALF);
        cs_n <= !on;
        si <= !si;
        tick(HALF);
    endtask
    // One byte each way, top bit first; output sampled after each fall.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            tick(HALF);
            if (i < 7) rx[i+1] = so;
            sck <= 1'b1;
            tick(HALF);
            sck <= 1'b0;
        end
        tick(HALF);
        rx[0] = so;
    endtask
    // Clock and data toggle together, as noise during a pause or as parallel clock pulses.
    task automatic noise(input int n);
        repeat (n) begin
            si <= !si;
            sck <= 1'b1;
            tick(HALF);
            sck <= 1'b0;
            tick(HALF);
        end
    endtask
endmodule

// File: sim/sfpi_top_asserts.sv
`timescale 1ns/1ps
// --------------------
// Pin checks
// --------------------
module sfpi_top_asserts (
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic device_select_n,
    input wire logic pause_n,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic protect_accel_n,
    input wire logic accel_voltage,
    input wire logic addr_protected,
    input wire logic write_busy,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic tx_ready,
    input wire logic standby,
    input wire logic write_refused,
    input wire logic accel_mode
);
    // Pins cross a synchroniser, so levels get a few cycles to settle.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence s_desel;
        device_select_n [*5];
    endsequence
    sequence s_paused;
        (!device_select_n && !pause_n) [*5];
    endsequence
    property p_desel_float;
        s_desel |-> !serial_out_oe;
    endproperty
    a_desel_float: assert property (p_desel_float)
        else $error("output driven while deselected");
    property p_pause_float;
        s_paused |-> !serial_out_oe;
    endproperty
    a_pause_float: assert property (p_pause_float)
        else $error("output driven while paused");
    property p_standby;
        (device_select_n && !write_busy) [*6] |-> standby;
    endproperty
    a_standby: assert property (p_standby)
        else $error("no standby when idle");
    property p_awake;
        !device_select_n [*6] |-> !standby;
    endproperty
    a_awake: assert property (p_awake)
        else $error("standby while selected");
    property p_busy;
        write_busy [*2] |-> !standby;
    endproperty
    a_busy: assert property (p_busy)
        else $error("standby while busy");
    property p_refuse;
        $stable({protect_accel_n, addr_protected}) [*6]
            |-> write_refused == (!protect_accel_n && addr_protected);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("write refusal wrong");
    property p_accel;
        $stable(accel_voltage) [*6] |-> accel_mode == accel_voltage;
    endproperty
    a_accel: assert property (p_accel)
        else $error("accelerated mode wrong");
    property p_tx_pulse;
        tx_ready |=> !tx_ready;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("byte taken twice");
    property p_rx_hold;
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("byte dropped under stall");
    property p_out_edge;
        serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
            |-> !serial_clk;
    endproperty
    a_out_edge: assert property (p_out_edge)
        else $error("output moved while clock high");
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
// --------------------
// Bench
// --------------------
module tb;
    import sfpi_pkg::*;
    logic clock, reset = 1'b1, pause_n = 1'b1, rx_ready = 1'b1;
    logic protect_accel_n = 1'b1, accel_voltage = 1'b0, tx_valid = 1'b0;
    logic addr_protected = 1'b0, write_busy = 1'b0, so_last = 1'b0;
    logic parallel_mode = 1'b0;
    logic sck, cs_n, si, serial_out, serial_out_oe, rx_valid, rx_first;
    logic tx_ready, selected, standby, write_refused, accel_mode, overrun;
    logic [7:0] parallel_io_in = 8'h00, tx_data = 8'h00;
    logic [7:0] parallel_io_out, parallel_io_oe, rx_data, v, w, got;
    logic [8:0] exp_q[$];
    logic [31:0] seed = 32'h8C36;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    // A released output line shows the inverse of its last driven bit.
    wire logic so_w = serial_out_oe ? serial_out : !so_last;
    sfpi_top sfpi_top_inst (.clock(clock), .reset(reset),
        .serial_clk(sck), .device_select_n(cs_n), .pause_n(pause_n),
        .serial_in(si), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .parallel_io_in(parallel_io_in),
        .parallel_io_out(parallel_io_out), .parallel_io_oe(parallel_io_oe),
        .parallel_mode(parallel_mode), .protect_accel_n(protect_accel_n),
        .accel_voltage(accel_voltage), .addr_protected(addr_protected),
        .write_busy(write_busy), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_first(rx_first), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .selected(selected),
        .standby(standby), .write_refused(write_refused),
        .accel_mode(accel_mode), .overrun(overrun));
    sfpi_master sfpi_master_inst (.clock(clock), .sck(sck), .cs_n(cs_n),
        .si(si), .so(so_w));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: byte %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: flag %b exp %b", $time, g, e);
        end
    endtask
    // Notes one byte as expected and sends it.
    task automatic send(input logic f);
        v = seed[7:0];
        exp_q.push_back({f, v});
        sfpi_master_inst.xfer(v, got);
    endtask
    // Notes one parallel byte and gives it one clock pulse.
    task automatic psend(input logic f);
        v = seed[7:0];
        parallel_io_in <= v;
        exp_q.push_back({f, v});
        sfpi_master_inst.tick(2);
        sfpi_master_inst.noise(1);
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Side levels change at random every 64 cycles; a hang is cut short.
    always @(posedge clock) begin
        seed <= lfsr(seed);
        cycles <= cycles + 1;
        if (!parallel_mode) parallel_io_in <= seed[15:8];
        if (serial_out_oe === 1'b1) so_last <= serial_out;
        if (tx_ready === 1'b1) tx_valid <= 1'b0;
        if (cycles[5:0] == 6'h3F) begin
            protect_accel_n <= seed[1];
            accel_voltage <= seed[1] & seed[2];
            addr_protected <= seed[3];
            write_busy <= seed[4];
        end
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // Every delivered byte is matched against the oldest note.
    always @(posedge clock) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            checks_done++;
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("wrong value at %0t: unexpected byte", $time);
            end else begin
                cmp8(rx_data, exp_q[0][7:0]);
                cmp1(rx_first, exp_q[0][8]);
                void'(exp_q.pop_front());
            end
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        sfpi_master_inst.xfer(8'hA5, got);
        sfpi_master_inst.sel(1'b0);
        $display("test locked done");
        for (int f = 0; f < 3; f++) begin
            sfpi_master_inst.sel(1'b1);
            cmp1(selected, 1'b1);
            for (int b = 0; b < 3; b++) send(b == 0);
            sfpi_master_inst.sel(1'b0);
            cmp1(selected, 1'b0);
        end
        $display("test frames done");
        for (int k = 0; k < 2; k++) begin
            w = seed[15:8];
            tx_data <= w;
            tx_valid <= (k == 0);
            sfpi_master_inst.sel(1'b1);
            send(1'b1);
            sfpi_master_inst.sel(1'b0);
            cmp8(got, (k == 0) ? w : SFPI_IDLE_FILL);
        end
        $display("test output done");
        sfpi_master_inst.sel(1'b1);
        send(1'b1);
        pause_n <= 1'b0;
        sfpi_master_inst.tick(4);
        sfpi_master_inst.noise(8);
        pause_n <= 1'b1;
        sfpi_master_inst.tick(4);
        send(1'b0);
        sfpi_master_inst.sel(1'b0);
        $display("test pause done");
        w = seed[15:8];
        tx_data <= w;
        tx_valid <= 1'b1;
        parallel_mode <= 1'b1;
        sfpi_master_inst.sel(1'b1);
        psend(1'b1);
        cmp8(parallel_io_out, w);
        cmp8(parallel_io_oe, 8'hFF);
        cmp1(serial_out_oe, 1'b0);
        psend(1'b0);
        cmp8(parallel_io_out, SFPI_IDLE_FILL);
        sfpi_master_inst.sel(1'b0);
        parallel_mode <= 1'b0;
        $display("test parallel done");
        rx_ready <= 1'b0;
        sfpi_master_inst.sel(1'b1);
        send(1'b1);
        send(1'b0);
        sfpi_master_inst.xfer(seed[7:0], got);
        sfpi_master_inst.sel(1'b0);
        cmp1(overrun, 1'b1);
        rx_ready <= 1'b1;
        sfpi_master_inst.sel(1'b1);
        cmp1(exp_q.size() == 0, 1'b1);
        cmp1(overrun, 1'b0);
        sfpi_master_inst.sel(1'b0);
        $display("test stall done");
        complete_run();
    end
endmodule
bind sfpi_top sfpi_top_asserts sfpi_top_asserts_inst (.clock(clock),
    .reset(reset), .serial_clk(serial_clk),
    .device_select_n(device_select_n), .pause_n(pause_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .protect_accel_n(protect_accel_n), .accel_voltage(accel_voltage),
    .addr_protected(addr_protected), .write_busy(write_busy),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_ready(tx_ready), .standby(standby),
    .write_refused(write_refused), .accel_mode(accel_mode));
